// ### verif/swic_switch_input_config_assertions.sv
`timescale 1ns/1ps
`include "swic_regs.vh"

// ----------------------------------------------
// Port-level checks for the switch input block
// ----------------------------------------------
module swic_switch_input_config_chk #(
    parameter NIN  = 24,
    parameter NSEL = 10
) (
    input wire           core_clk,
    input wire           rst_b,
    input wire [7:0]     regAddr,
    input wire [31:0]    regWrData,
    input wire           regWrEn,
    input wire           regRdEn,
    input wire [31:0]    regRdData,
    input wire [NIN-1:0] cmpAbove,
    input wire           tempWarn,
    input wire           overVolt,
    input wire [NIN-1:0] sinkSelect,
    input wire [NIN-1:0] wetEnable,
    input wire [71:0]    wetLevel,
    input wire [47:0]    threshLevel,
    input wire           runActive,
    input wire           irq,
    input wire           eventPinOut,
    input wire           eventPinOe_b
);
    logic wetOk;
    logic thrOk;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Field scan; flags keep the wetting code check and the threshold sharing check to one line each
    always_comb begin
        wetOk = 1'b1;
        thrOk = 1'b1;
        for (int i = 0; i < NIN; i++) begin
            if (wetLevel[3*i+:3] > 3'h5)
                wetOk = 1'b0;
            if (!wetEnable[i] && wetLevel[3*i+:3] != 3'h0)
                wetOk = 1'b0;
            if (threshLevel[2*i+:2] != threshLevel[8*(i/4)+:2])
                thrOk = 1'b0;
        end
    end

    chk_src_fixed: assert property (sinkSelect[NIN-1:NSEL] == '0)
        else $error("upper inputs left source mode");
    chk_reset_clear: assert property ($rose(rst_b) |->
        sinkSelect == '0 && wetEnable == '0 && wetLevel == '0)
        else $error("settings not cleared by reset");
    chk_sink_write: assert property (regWrEn && !runActive &&
        regAddr == `SWIC_OFF_SRCSINK |=>
        sinkSelect[NSEL-1:0] == $past(regWrData[NSEL-1:0]))
        else $error("sink select did not follow write");
    chk_wet_gate: assert property (!runActive |-> wetEnable == '0)
        else $error("wetting on while stopped");
    chk_wet_codes: assert property (wetOk)
        else $error("wetting level illegal or on when disabled");
    chk_thr_group: assert property (thrOk)
        else $error("threshold differs inside a group");
    chk_wet_pairs: assert property (
        (!(wetEnable[0] && wetEnable[1]) || wetLevel[2:0] == wetLevel[5:3])
        && (!(wetEnable[12] && wetEnable[13]) ||
        wetLevel[38:36] == wetLevel[41:39]))
        else $error("paired inputs differ in wetting");
    chk_pin_drive: assert property (!eventPinOut &&
        eventPinOe_b == !irq)
        else $error("event pin does not follow interrupt");
    chk_mask_quiet: assert property (regWrEn &&
        regAddr == `SWIC_OFF_INTMASK && regWrData[2:0] == 3'h0 |=> !irq)
        else $error("interrupt high with all masked");
endmodule

bind swic_switch_input_config swic_switch_input_config_chk #(
    .NIN(NIN), .NSEL(NSEL)
) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .cmpAbove(cmpAbove), .tempWarn(tempWarn),
    .overVolt(overVolt), .sinkSelect(sinkSelect), .wetEnable(wetEnable),
    .wetLevel(wetLevel), .threshLevel(threshLevel),
    .runActive(runActive), .irq(irq), .eventPinOut(eventPinOut),
    .eventPinOe_b(eventPinOe_b)
);

// ### verif/swic_switch_model.sv
`timescale 1ns/1ps

// ----------------------------------
// Switch bank and event pin pull-up
// ----------------------------------
module swic_switch_model (
    input  wire [23:0] sinkSelect,
    input  wire [23:0] closed,
    input  wire        eventPinOut,
    input  wire        eventPinOe_b,
    output wire [23:0] cmpAbove,
    output wire        evtLine
);
    // Closed source pin sits low, closed sink pin sits high
    assign cmpAbove = closed ^ ~sinkSelect;
    // Released pin is pulled up, never left at the old level
    assign evtLine = eventPinOe_b ? 1'b1 : eventPinOut;
endmodule

// ### verif/tb_swic_switch_input_config.sv
`timescale 1ns/1ps
`include "swic_regs.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    error_cnt++; $display("BAD %s exp %h got %h", n, e, a); end end

module tb_swic_switch_input_config;
    logic        core_clk = 0, rst_b = 0, regWrEn = 0, regRdEn = 0;
    logic        tempWarn = 0, overVolt = 0, irq, runActive;
    logic        eventPinOut, eventPinOe_b, evtLine;
    logic [7:0]  regAddr = 0;
    logic [31:0] regWrData = 0, regRdData, wa, wb;
    logic [23:0] closed = 0, cmpAbove, sinkSelect, wetEnable;
    logic [71:0] wetLevel, expWet;
    logic [47:0] threshLevel, expThr;
    int          error_cnt = 0, comparisons = 0;
    int          fieldOf[24] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5, 6, 7,
                                 8, 8, 9, 9, 10, 10, 11, 11, 12, 12, 13, 14};

    swic_switch_input_config u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .cmpAbove(cmpAbove),
        .tempWarn(tempWarn), .overVolt(overVolt), .sinkSelect(sinkSelect),
        .wetEnable(wetEnable), .wetLevel(wetLevel),
        .threshLevel(threshLevel), .runActive(runActive), .irq(irq),
        .eventPinOut(eventPinOut), .eventPinOe_b(eventPinOe_b));
    swic_switch_model u_sw (.sinkSelect(sinkSelect), .closed(closed),
        .eventPinOut(eventPinOut), .eventPinOe_b(eventPinOe_b),
        .cmpAbove(cmpAbove), .evtLine(evtLine));

    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;

    // ------------------------------
    // Register bus tasks
    // ------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        @(posedge core_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        `CHK(n, e, regRdData)
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog so a stuck sequence still reaches the verdict
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        stop_test;
    end

    // ------------------------------
    // Test sequence
    // ------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(`SWIC_OFF_SRCSINK, 0, "srcsink");
        rd(`SWIC_OFF_INEN, 0, "inen");
        rd(`SWIC_OFF_WETA, 0, "weta");
        rd(`SWIC_OFF_WETB, 0, "wetb");
        rd(8'h24, 0, "unmapped");
        `CHK("sinkPin", 24'h0, sinkSelect)
        $display("Test reset done");
        wa = 0;
        wb = 0;
        for (int f = 0; f < 15; f++)
            if (f < 8) wa[3*f+:3] = 3'(f % 6);
            else wb[3*(f-8)+:3] = 3'(f % 6);
        for (int i = 0; i < 24; i++) begin
            expThr[2*i+:2] = 2'(12'h6e4 >> (2 * (i / 4)));
            expWet[3*i+:3] = 3'(fieldOf[i] % 6);
        end
        wr(`SWIC_OFF_SRCSINK, 32'h3ff);
        wr(`SWIC_OFF_THRESH, 32'h6e4);
        wr(`SWIC_OFF_WETA, wa);
        wr(`SWIC_OFF_WETB, wb);
        wr(`SWIC_OFF_INEN, 32'hff_ffff);
        #1;
        `CHK("sinkPin", 24'h3ff, sinkSelect)
        `CHK("thrPin", expThr, threshLevel)
        `CHK("wetOff", 72'h0, wetLevel)
        @(posedge core_clk) closed <= 24'ha5c3f0;
        wr(`SWIC_OFF_CONFIG, 1);
        #1;
        `CHK("runPin", 1'b1, runActive)
        wr(`SWIC_OFF_SRCSINK, 0);
        repeat (6) @(posedge core_clk);
        #1;
        `CHK("wetPin", expWet, wetLevel)
        rd(`SWIC_OFF_SRCSINK, 32'h3ff, "refused");
        rd(`SWIC_OFF_STATE, 32'ha5c3f0, "state");
        rd(`SWIC_OFF_INTSTAT, 0, "noEvent");
        $display("Test config done");
        @(posedge core_clk) closed <= 24'h5a3c0f;
        repeat (6) @(posedge core_clk);
        rd(`SWIC_OFF_STATE, 32'h5a3c0f, "state2");
        `CHK("irqMasked", 1'b0, irq)
        wr(`SWIC_OFF_INTMASK, 7);
        #1;
        `CHK("evtPin", 1'b0, evtLine)
        rd(`SWIC_OFF_INTSTAT, 1, "change");
        for (int b = 1; b < 3; b++) begin
            wr(`SWIC_OFF_INTSTAT, 7);
            @(posedge core_clk);
            if (b == 1) tempWarn <= 1'b1;
            else overVolt <= 1'b1;
            repeat (6) @(posedge core_clk);
            rd(`SWIC_OFF_INTSTAT, 32'(1 << b), "event");
        end
        wr(`SWIC_OFF_INTMASK, 0);
        #1;
        `CHK("evtMasked", 1'b1, evtLine)
        wr(`SWIC_OFF_INTMASK, 7);
        wr(`SWIC_OFF_INTSTAT, 7);
        #1;
        `CHK("evtIdle", 1'b1, evtLine)
        $display("Test events done");
        wr(`SWIC_OFF_CONFIG, 0);
        wr(`SWIC_OFF_WETA, 32'h7);
        wr(`SWIC_OFF_INEN, 32'hff);
        wr(`SWIC_OFF_CONFIG, 1);
        repeat (6) @(posedge core_clk);
        rd(`SWIC_OFF_STATE, 32'h0f, "partial");
        `CHK("wetEn", 24'hff, wetEnable)
        `CHK("wetClamp", 6'h0, wetLevel[5:0])
        rd(`SWIC_OFF_WETA, 32'h7, "wetRaw");
        $display("Test disable done");
        stop_test;
    end
endmodule

// ### verilog/swic_regs.vh
`ifndef SWIC_REGS_VH
`define SWIC_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define SWIC_OFF_CONFIG    8'h00
`define SWIC_OFF_SRCSINK   8'h04
`define SWIC_OFF_INEN      8'h08
`define SWIC_OFF_THRESH    8'h0c
`define SWIC_OFF_WETA      8'h10
`define SWIC_OFF_WETB      8'h14
`define SWIC_OFF_STATE     8'h18
`define SWIC_OFF_INTSTAT   8'h1c
`define SWIC_OFF_INTMASK   8'h20

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SWIC_CFG_RUN_BIT   0
`define SWIC_CFG_RST       32'h0000_0000
`define SWIC_SRCSINK_RST   10'h000
`define SWIC_INEN_RST      24'h00_0000
`define SWIC_THRESH_RST    12'h000
`define SWIC_WET_RST       3'h0
`define SWIC_WET_W         3
`define SWIC_THR_W         2
`define SWIC_WET_MAX       3'h5

// Interrupt status bit positions
`define SWIC_EV_CHANGE     0
`define SWIC_EV_TEMP       1
`define SWIC_EV_OVER       2

`endif

// ### verilog/swic_switch_input_config.v
//
// Notes on behaviour
// - Report open/closed state of every input.
// - Inputs 10-23 fixed to current source.
// - Inputs 0-9 reset to current source.
// - Writing one selects sink for 0-9.
// - Disabled input: no wetting, no monitoring.
// - Input enable clears on reset.
// - Threshold per group of four inputs.
// - Threshold codes 2, 2.7, 3, 4 V.
// - Wetting codes 0,1,2,5,10,15 mA.
// - Wetting fields reset to 0 mA.
// - Settings shared in fours and pairs.
// - Event pin active-low open drain.
//
`timescale 1ns/1ps
`include "swic_regs.vh"

module swic_switch_input_config #(
    parameter NIN  = 24,
    parameter NSEL = 10
) (
    input  wire            core_clk,
    input  wire            rst_b,
    input  wire [7:0]      regAddr,
    input  wire [31:0]     regWrData,
    input  wire            regWrEn,
    input  wire            regRdEn,
    output reg  [31:0]     regRdData,
    input  wire [NIN-1:0]  cmpAbove,
    input  wire            tempWarn,
    input  wire            overVolt,
    output wire [NIN-1:0]  sinkSelect,
    output wire [NIN-1:0]  wetEnable,
    output wire [71:0]     wetLevel,
    output wire [47:0]     threshLevel,
    output wire            runActive,
    output wire            irq,
    output wire            eventPinOut,
    output wire            eventPinOe_b
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Map an input to its wetting field (15 fields, some shared)
    function [4:0] wetField;
        input [4:0] idx;
        begin
            case (idx)
                5'd0, 5'd1:   wetField = 5'd0;
                5'd2, 5'd3:   wetField = 5'd1;
                5'd4:         wetField = 5'd2;
                5'd5:         wetField = 5'd3;
                5'd6, 5'd7:   wetField = 5'd4;
                5'd8, 5'd9:   wetField = 5'd5;
                5'd10:        wetField = 5'd6;
                5'd11:        wetField = 5'd7;
                5'd12, 5'd13: wetField = 5'd8;
                5'd14, 5'd15: wetField = 5'd9;
                5'd16, 5'd17: wetField = 5'd10;
                5'd18, 5'd19: wetField = 5'd11;
                5'd20, 5'd21: wetField = 5'd12;
                5'd22:        wetField = 5'd13;
                5'd23:        wetField = 5'd14;
                default:      wetField = 5'd0;
            endcase
        end
    endfunction

    // Clamp unused wetting codes to 0 mA
    function [2:0] wetLegal;
        input [2:0] code;
        begin
            wetLegal = (code > `SWIC_WET_MAX) ? `SWIC_WET_RST : code;
        end
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [31:0]    config_r;
    reg  [NSEL-1:0] srcSink_r;
    reg  [NIN-1:0] inEn_r;
    reg  [11:0]    thresh_r;
    reg  [44:0]    wetCfg_r;
    reg  [NIN-1:0] state_r;
    reg  [NIN-1:0] prevState_r;
    reg            primed_r;
    reg  [2:0]     intStat_r;
    reg  [2:0]     intMask_r;
    reg  [2:0]     intStat_nxt;
    reg            tempWarnD_r;
    reg            overVoltD_r;
    wire [NIN-1:0] cmpSync;
    wire           tempSync;
    wire           overSync;
    wire           cfgWrite;
    wire           changeEv;
    wire           tempEv;
    wire           overEv;
    wire [NIN-1:0] stateSample;
    wire           wrConfig;
    wire           wrMask;
    wire           wrStat;
    wire           wrSrcSink;
    wire           wrInEn;
    wire           wrThresh;
    wire           wrWetA;
    wire           wrWetB;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    swic_sync #(
        .W (NIN + 2)
    ) uSync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .asyncIn  ({overVolt, tempWarn, cmpAbove}),
        .syncOut  ({overSync, tempSync, cmpSync})
    );

    // Configuration only changes while stopped; writes while running
    // are dropped so a live poll never sees half-updated settings.
    assign cfgWrite  = regWrEn && !config_r[`SWIC_CFG_RUN_BIT];
    assign runActive = config_r[`SWIC_CFG_RUN_BIT];

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Run control, mask and status clear stay writable while running
    assign wrConfig  = regWrEn && regAddr == `SWIC_OFF_CONFIG;
    assign wrMask    = regWrEn && regAddr == `SWIC_OFF_INTMASK;
    assign wrStat    = regWrEn && regAddr == `SWIC_OFF_INTSTAT;
    // Settings strobes are gated by the run bit; unmapped offsets
    // match none of them and are dropped
    assign wrSrcSink = cfgWrite && regAddr == `SWIC_OFF_SRCSINK;
    assign wrInEn    = cfgWrite && regAddr == `SWIC_OFF_INEN;
    assign wrThresh  = cfgWrite && regAddr == `SWIC_OFF_THRESH;
    assign wrWetA    = cfgWrite && regAddr == `SWIC_OFF_WETA;
    assign wrWetB    = cfgWrite && regAddr == `SWIC_OFF_WETB;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Run bit and mask, never locked
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            config_r  <= `SWIC_CFG_RST;
            intMask_r <= 3'h0;
        end else begin
            if (wrConfig) begin
                config_r <= {31'h0, regWrData[`SWIC_CFG_RUN_BIT]};
            end
            if (wrMask) begin
                intMask_r <= regWrData[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Input settings, written only while stopped
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            srcSink_r <= `SWIC_SRCSINK_RST;
            inEn_r    <= `SWIC_INEN_RST;
            thresh_r  <= `SWIC_THRESH_RST;
            wetCfg_r  <= {15{`SWIC_WET_RST}};
        end else begin
            if (wrSrcSink) begin
                srcSink_r <= regWrData[NSEL-1:0];
            end
            if (wrInEn) begin
                inEn_r <= regWrData[NIN-1:0];
            end
            if (wrThresh) begin
                thresh_r <= regWrData[11:0];
            end
            if (wrWetA) begin
                wetCfg_r[23:0] <= regWrData[23:0];
            end
            if (wrWetB) begin
                wetCfg_r[44:24] <= regWrData[20:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Per-input drive outputs
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1) begin : gInput
            localparam [4:0] IDX = gi;
            wire [4:0] fld;
            assign fld = wetField(IDX);
            // Inputs above the selectable range are tied to source
            if (gi < NSEL) begin : gSel
                assign sinkSelect[gi] = srcSink_r[gi];
            end else begin : gFix
                assign sinkSelect[gi] = 1'b0;
            end
            // Off while disabled or stopped
            assign wetEnable[gi] = inEn_r[gi] && runActive;
            // Shared pair fields drive both inputs
            assign wetLevel[gi*3 +: 3] = wetEnable[gi] ?
                wetLegal(wetCfg_r[fld*3 +: 3]) : 3'h0;
            // Two-bit code: 0=2V 1=2.7V 2=3V 3=4V
            assign threshLevel[gi*2 +: 2] =
                thresh_r[(gi/4)*2 +: 2];
        end
    endgenerate

    // ------------------------------------------------------------
    // Switch state tracking
    // ------------------------------------------------------------
    // Closed: comparator low for source, high for sink
    assign stateSample = wetEnable & (cmpSync ^ ~sinkSelect);

    // Disabled inputs freeze at open (0); first sample after start
    // only sets a baseline so no spurious change is raised.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r     <= {NIN{1'b0}};
            prevState_r <= {NIN{1'b0}};
            primed_r    <= 1'b0;
            tempWarnD_r <= 1'b0;
            overVoltD_r <= 1'b0;
        end else begin
            tempWarnD_r <= tempSync;
            overVoltD_r <= overSync;
            if (runActive) begin
                state_r     <= stateSample;
                // First run cycle compares the sample with itself
                prevState_r <= primed_r ? state_r : stateSample;
                primed_r    <= 1'b1;
            end else begin
                primed_r    <= 1'b0;
            end
        end
    end

    // Change raised once two successive samples differ
    assign changeEv = runActive && primed_r &&
                      (state_r != prevState_r);
    // Warnings flag on the rising edge only, not while held
    assign tempEv   = tempSync && !tempWarnD_r;
    assign overEv   = overSync && !overVoltD_r;

    // ------------------------------------------------------------
    // Interrupt status, write-one-to-clear, set wins
    // ------------------------------------------------------------
    always @* begin
        intStat_nxt = intStat_r;
        if (wrStat) begin
            intStat_nxt = intStat_r & ~regWrData[2:0];
        end
        intStat_nxt = intStat_nxt |
                      {overEv, tempEv, changeEv};
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            intStat_r <= 3'h0;
        end else begin
            intStat_r <= intStat_nxt;
        end
    end

    // Level interrupt: any unmasked sticky bit
    assign irq          = |(intStat_r & intMask_r);
    // Open drain: only ever pulls low, oe_b low while driving
    assign eventPinOut  = 1'b0;
    assign eventPinOe_b = ~irq;

    // ------------------------------------------------------------
    // Read path, one cycle latency
    // ------------------------------------------------------------
    // Idle cycles read zero so a stale word never looks valid
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 32'h0;
        end else if (regRdEn) begin
            case (regAddr)
                `SWIC_OFF_CONFIG:  regRdData <= config_r;
                `SWIC_OFF_SRCSINK: regRdData <= {22'h0, srcSink_r};
                `SWIC_OFF_INEN:    regRdData <= {8'h0, inEn_r};
                `SWIC_OFF_THRESH:  regRdData <= {20'h0, thresh_r};
                `SWIC_OFF_WETA:    regRdData <= {8'h0, wetCfg_r[23:0]};
                `SWIC_OFF_WETB:    regRdData <= {11'h0, wetCfg_r[44:24]};
                `SWIC_OFF_STATE:   regRdData <= {8'h0, state_r};
                `SWIC_OFF_INTSTAT: regRdData <= {29'h0, intStat_r};
                `SWIC_OFF_INTMASK: regRdData <= {29'h0, intMask_r};
                default:           regRdData <= 32'h0;
            endcase
        end else begin
            regRdData <= 32'h0;
        end
    end
endmodule

// ### verilog/swic_sync.v
`timescale 1ns/1ps

// Two-flop synchroniser for a bus of asynchronous levels
module swic_sync #(
    parameter W = 1
) (
    input  wire         core_clk,
    input  wire         rst_b,
    input  wire [W-1:0] asyncIn,
    output wire [W-1:0] syncOut
);
    reg [W-1:0] stage1_r;
    reg [W-1:0] stage2_r;

    // First stage is read only by the second stage
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_r <= {W{1'b0}};
            stage2_r <= {W{1'b0}};
        end else begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;
endmodule
